// ### core/asc_core.sv
/*
 * serial control, framing and internal-clock readout of a 16-bit converter,
 * with a result fifo module in the data path.
 * assumes: serial pins are asynchronous and are synchronised here; the
 * analog converter supplies a sample word on i_sample; i_clock is 250 MHz.
 */
`timescale 1ns/1ps
`include "asc_regs.svh"

module asc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} asc_fifo_st_t;
	asc_fifo_st_t s_q, s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	always_comb begin
		o_in_ready = (s_q.wp - s_q.rp) != (AW+1)'(DEPTH);
		o_out_valid = s_q.wp != s_q.rp;
		o_out_data = mem[s_q.rp[AW-1:0]];
		push = i_in_valid && o_in_ready;
		pop = o_out_valid && i_out_ready;
		s_d = s_q;
		if (push) begin
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
		if (i_flush) begin
			s_d = '0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			s_q <= '0;
		end else if (i_ce) begin
			s_q <= s_d;
			if (push) begin
				mem[s_q.wp[AW-1:0]] <= i_in_data;
			end
		end
	end
endmodule

module asc_core (
	// clock, reset, enable
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_hw_rst_n,
	input wire logic i_shdn_n,
	// serial link
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_din,
	output logic o_dout,
	output logic o_dout_oe,
	output logic o_conv_strobe,
	output logic o_conv_strobe_oe,
	// converter side
	input wire logic [15:0] i_sample,
	output logic o_polarity_select,
	output logic o_conv_clock_select,
	output logic [1:0] o_mode,
	output logic o_cal_busy,
	output logic o_power_down,
	// general-purpose outputs
	output logic [2:0] o_gp_out
);
	localparam int STROBE_MAX_CYC = (`ASC_STROBE_MAX_NS * `ASC_CLK_MHZ) / 1000;
	localparam int CONV_CYC = (`ASC_CONV_NS * `ASC_CLK_MHZ) / 1000;

	typedef struct packed {
		logic [1:0] cs_s;
		logic [1:0] sck_s;
		logic [1:0] din_s;
		logic [1:0] rst_s;
		logic [1:0] shdn_s;
		logic cs_p;
		logic sck_p;
		asc_pkg::asc_state_t st;
		logic [7:0] sh;
		logic [3:0] nbits;
		logic armed;
		logic pol;
		logic intclk;
		logic [1:0] mode;
		logic [2:0] gp;
		logic [16:0] tmr;
		logic [5:0] extn;
		logic [15:0] res;
		logic [4:0] rdn;
		logic dout;
		logic dout_oe;
		logic strobe;
		logic strobe_oe;
		logic cal;
		logic pdown;
		logic pdn_o;
	} asc_st_t;
	asc_st_t s_q, s_d;

	logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
	logic [15:0] f_in_data, f_out_data;

	// unipolar is straight binary; bipolar flips the offset-binary msb
	function automatic logic [15:0] fmt_result(input logic uni, input logic [15:0] raw);
		fmt_result = uni ? raw : {~raw[15], raw[14:0]};
	endfunction

	asc_fifo #(.WIDTH(16), .DEPTH(`ASC_FIFO_DEPTH)) u_fifo (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_flush(f_flush),
		.i_in_valid(f_in_valid),
		.o_in_ready(f_in_ready),
		.i_in_data(f_in_data),
		.o_out_valid(f_out_valid),
		.i_out_ready(f_out_ready),
		.o_out_data(f_out_data)
	);

	logic cs, sck_rise, sck_fall, cs_fall, cs_rise, hw_rst;

	always_comb begin
		s_d = s_q;
		s_d.cs_s = {s_q.cs_s[0], i_cs_n};
		s_d.sck_s = {s_q.sck_s[0], i_sclk};
		s_d.din_s = {s_q.din_s[0], i_din};
		s_d.rst_s = {s_q.rst_s[0], i_hw_rst_n};
		s_d.shdn_s = {s_q.shdn_s[0], i_shdn_n};
		s_d.cs_p = s_q.cs_s[1];
		s_d.sck_p = s_q.sck_s[1];
		cs = !s_q.cs_s[1];
		cs_fall = s_q.cs_p && !s_q.cs_s[1];
		cs_rise = !s_q.cs_p && s_q.cs_s[1];
		sck_rise = cs && !s_q.sck_p && s_q.sck_s[1];
		sck_fall = cs && s_q.sck_p && !s_q.sck_s[1];
		hw_rst = !s_q.rst_s[1];
		f_in_valid = 1'b0;
		f_in_data = fmt_result(s_q.pol, i_sample);
		f_out_ready = 1'b0;
		f_flush = 1'b0;
		s_d.pdown = s_q.pdown && s_q.shdn_s[1];
		// gp outputs are never touched by shutdown paths
		s_d.gp = s_q.gp;

		if (cs_fall) begin
			s_d.armed = 1'b1;
		end
		if (cs_rise) begin
			s_d.dout_oe = 1'b0;
			s_d.strobe_oe = s_q.intclk;
		end
		if (cs_fall) begin
			s_d.dout_oe = 1'b1;
			s_d.strobe_oe = 1'b1;
		end

		// conversion timer counts down only while the internal clock is selected
		if (s_q.st == asc_pkg::ST_CONV && s_q.intclk && s_q.tmr != '0) begin
			s_d.tmr = s_q.tmr - 1'b1;
		end
		if (s_q.st == asc_pkg::ST_CONV && s_q.intclk && s_q.tmr == 17'h0_0001) begin
			s_d.strobe = 1'b1;
			s_d.cal = 1'b0;
			if (s_q.mode != asc_pkg::MODE_CAL && f_in_ready) begin
				f_in_valid = 1'b1;
			end
			s_d.st = asc_pkg::ST_READ;
			s_d.armed = 1'b1;
		end

		// result word leaves the fifo one cycle after the strobe rises, msb first
		if (s_q.st == asc_pkg::ST_READ && s_q.rdn == '0 && f_out_valid) begin
			f_out_ready = 1'b1;
			s_d.res = f_out_data;
			s_d.dout = f_out_data[15];
			s_d.rdn = `ASC_RES_BITS - 5'h01;
		end else if (sck_fall && s_q.rdn != '0) begin
			s_d.res = {s_q.res[14:0], 1'b0};
			s_d.dout = s_q.res[14];
			s_d.rdn = s_q.rdn - 1'b1;
		end

		// external-clock conversion counts serial clock falls
		if (s_q.st == asc_pkg::ST_CONV && !s_q.intclk && sck_fall) begin
			s_d.extn = s_q.extn + 1'b1;
			if (s_q.extn == s_q.tmr[5:0] - 6'(`ASC_CMD_BITS)) begin
				s_d.st = asc_pkg::ST_IDLE;
				s_d.armed = 1'b1;
				s_d.cal = 1'b0;
			end
		end

		if (sck_rise) begin
			if (s_q.armed && s_q.din_s[1]) begin
				// a start bit here abandons any running operation
				s_d.st = asc_pkg::ST_CMD;
				s_d.sh = 8'h01;
				s_d.nbits = 4'h1;
				s_d.armed = 1'b0;
				s_d.strobe = 1'b1;
				s_d.rdn = '0;
				s_d.cal = 1'b0;
				f_flush = 1'b1;
			end else if (s_q.nbits != 4'h0 && s_q.nbits < `ASC_CMD_BITS) begin
				// the eighth bit lands after the conversion has already begun
				s_d.sh = {s_q.sh[6:0], s_q.din_s[1]};
				s_d.nbits = s_q.nbits + 1'b1;
				if (s_q.nbits == `ASC_P1_BIT_NUM) begin
					s_d.pol = s_q.sh[`ASC_BIT_POL - 1];
					s_d.intclk = s_q.sh[`ASC_BIT_CLK - 1];
					s_d.mode = s_q.sh[`ASC_BIT_MHI-1:`ASC_BIT_MLO-1];
					s_d.gp = {s_q.sh[`ASC_GP_HI-1:`ASC_GP_LO], s_q.din_s[1]};
					// power-down re-arms only once the byte is whole, so its last bit is no start
					if (s_q.st == asc_pkg::ST_IDLE) begin
						s_d.armed = 1'b1;
					end
				end
			end
		end

		if (sck_fall && s_q.st == asc_pkg::ST_CMD && s_q.nbits >= `ASC_P1_BIT_NUM) begin
			// conversion begins on the fall after the seventh bit
			s_d.st = asc_pkg::ST_CONV;
			s_d.extn = '0;
			s_d.mode = s_q.mode;
			s_d.pol = s_q.sh[`ASC_BIT_POL - 1];
			s_d.intclk = s_q.sh[`ASC_BIT_CLK - 1];
			case (asc_pkg::asc_mode_t'(s_q.sh[`ASC_BIT_MHI-1:`ASC_BIT_MLO-1]))
				asc_pkg::MODE_CAL: begin
					s_d.cal = 1'b1;
					s_d.tmr = 17'(`ASC_CAL_CYCLES);
				end
				asc_pkg::MODE_PDOWN: begin
					s_d.pdown = 1'b1;
					s_d.st = asc_pkg::ST_IDLE;
				end
				asc_pkg::MODE_LONG: begin
					s_d.tmr = s_q.sh[`ASC_BIT_CLK-1] ? 17'(CONV_CYC) : 17'(`ASC_EXT_LONG_CLKS);
				end
				default: begin
					s_d.tmr = s_q.sh[`ASC_BIT_CLK-1] ? 17'(CONV_CYC) : 17'(`ASC_EXT_SHORT_CLKS);
				end
			endcase
			if (s_q.sh[`ASC_BIT_CLK - 1] && s_d.st == asc_pkg::ST_CONV) begin
				s_d.strobe = 1'b0;
			end
		end

		if (hw_rst) begin
			s_d.gp = `ASC_GP_RESET;
			s_d.st = asc_pkg::ST_IDLE;
			s_d.armed = 1'b1;
			s_d.pol = 1'b0;
			s_d.intclk = 1'b1;
			s_d.strobe = 1'b1;
			s_d.rdn = '0;
			s_d.cal = 1'b0;
			s_d.nbits = 4'h0;
			// reset returns to internal clock, so the strobe must be driven again
			s_d.strobe_oe = 1'b1;
			f_flush = 1'b1;
		end
		s_d.pdn_o = s_d.pdown || !s_q.shdn_s[1];
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			s_q <= '0;
			s_q.cs_s <= 2'h3;
			s_q.cs_p <= 1'b1;
			s_q.rst_s <= 2'h3;
			s_q.shdn_s <= 2'h3;
			s_q.st <= asc_pkg::ST_IDLE;
			s_q.armed <= 1'b1;
			s_q.intclk <= 1'b1;
			s_q.strobe <= 1'b1;
			s_q.strobe_oe <= 1'b1;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	// strobe low time outside calibration limited by CONV_CYC, below STROBE_MAX_CYC
	logic unused_ok;
	assign unused_ok = (CONV_CYC < STROBE_MAX_CYC);

	always_comb begin
		o_dout = s_q.dout;
		o_dout_oe = s_q.dout_oe;
		o_conv_strobe = s_q.strobe;
		o_conv_strobe_oe = s_q.strobe_oe;
		o_polarity_select = s_q.pol;
		o_conv_clock_select = s_q.intclk;
		o_mode = s_q.mode;
		o_cal_busy = s_q.cal;
		o_power_down = s_q.pdn_o;
		o_gp_out = s_q.gp;
	end
endmodule

// ### core/asc_regs.svh
/*
 * register layout and timing constants for the converter serial control block.
 * assumes: included by the design file only, not by the package; definitions only.
 */
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

`define ASC_BIT_START 7
`define ASC_BIT_POL 6
`define ASC_BIT_CLK 5
`define ASC_BIT_MHI 4
`define ASC_BIT_MLO 3
`define ASC_GP_HI 2
`define ASC_GP_LO 0
`define ASC_GP_RESET 3'h0
`define ASC_CMD_BITS 4'h8
`define ASC_P1_BIT_NUM 4'h7
`define ASC_RES_BITS 5'h10
`define ASC_EXT_SHORT_CLKS 6'h18
`define ASC_EXT_LONG_CLKS 6'h20
`define ASC_CLK_MHZ 250
`define ASC_STROBE_MAX_NS 6000
`define ASC_CONV_NS 4000
`define ASC_CAL_CYCLES 80000
`define ASC_FIFO_DEPTH 16

`endif

// ### core/asc_pkg.sv
/*
 * types for the converter serial control block.
 * assumes: compiled before the design file.
 */
package asc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CMD = 4'b0010,
		ST_CONV = 4'b0100,
		ST_READ = 4'b1000
	} asc_state_t;

	typedef enum logic [1:0] {
		MODE_SHORT = 2'b00,
		MODE_CAL = 2'b01,
		MODE_PDOWN = 2'b10,
		MODE_LONG = 2'b11
	} asc_mode_t;
endpackage

// ### testbench/asc_core_properties.sv
/* port checker for asc_core.
   assumes: bound into every asc_core instance. */
`timescale 1ns/1ps
module asc_chk (
	// clock and resets
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_hw_rst_n,
	// serial link
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic o_dout_oe,
	input wire logic o_conv_strobe,
	input wire logic o_conv_strobe_oe,
	// status
	input wire logic o_conv_clock_select,
	input wire logic o_cal_busy,
	input wire logic [2:0] o_gp_out
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	// calibration runs far past the conversion limit, so it is not counted
	logic [10:0] lo_q;
	always_ff @(posedge i_clock) begin
		if (i_sys_rst || o_conv_strobe || o_cal_busy) begin
			lo_q <= 11'h000;
		end else begin
			lo_q <= lo_q + 11'h001;
		end
	end
	AST_GP_RST: assert property ($fell(i_sys_rst) |-> o_gp_out == 3'h0)
		else $error("gp not cleared");
	AST_GP_HWRST: assert property (!i_hw_rst_n [*4] |=> o_gp_out == 3'h0)
		else $error("gp not cleared by pin");
	AST_GP_HOLD: assert property ((i_cs_n && i_hw_rst_n) [*8] |-> $stable(o_gp_out))
		else $error("gp moved while idle");
	AST_DOUT_HIZ: assert property (i_cs_n [*5] |-> !o_dout_oe)
		else $error("dout driven");
	AST_DOUT_ON: assert property ((!i_cs_n && i_hw_rst_n) [*5] |-> o_dout_oe)
		else $error("dout not driven");
	AST_STRB_MAX: assert property (lo_q <= 11'h5dc)
		else $error("strobe low too long");
	AST_STRB_OE: assert property (o_conv_clock_select && i_cs_n |-> o_conv_strobe_oe)
		else $error("strobe released");
	AST_STRB_START: assert property ($fell(o_conv_strobe) && o_conv_clock_select
		|-> !i_sclk && $past(i_sclk, 12))
		else $error("strobe fell off a clock fall");
	AST_CAL_STRB: assert property ($rose(o_cal_busy) && o_conv_clock_select
		|-> ##[0:2] !o_conv_strobe)
		else $error("strobe high at calibration");
	cover property ($rose(o_conv_strobe));
	cover property ($rose(o_cal_busy));
	cover property (o_gp_out == 3'h7);
	cover property ($fell(o_dout_oe));
endmodule
bind asc_core asc_chk u_chk (.i_clock, .i_sys_rst, .i_hw_rst_n, .i_cs_n, .i_sclk,
	.o_dout_oe, .o_conv_strobe, .o_conv_strobe_oe, .o_conv_clock_select,
	.o_cal_busy, .o_gp_out);

// ### testbench/asc_host.sv
/* serial master model that talks to asc_core.
   assumes: paced by the 250 MHz system clock. */
`timescale 1ns/1ps
module asc_host #(
	parameter int CMD_HALF = 26,
	parameter int RD_HALF = 20
) (
	// pacing clock
	input wire logic i_clock,
	// serial link
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_din,
	input wire logic i_dout,
	input wire logic i_dout_oe
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_din = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic tick(input int h);
		o_sclk = 1'b1;
		wt(h);
		o_sclk = 1'b0;
		wt(h);
	endtask
	// bare clocks with a fixed din; zeros between commands send no stray start bit
	task automatic clocks(input int n, input logic d);
		o_cs_n = 1'b0;
		o_din = d;
		wt(CMD_HALF);
		repeat (n) tick(CMD_HALF);
		o_din = 1'b0;
	endtask
	task automatic send(input logic [7:0] b);
		o_cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			o_din = b[i];
			wt(CMD_HALF);
			tick(CMD_HALF);
		end
		o_din = 1'b0;
	endtask
	task automatic read(output logic [15:0] w);
		o_cs_n = 1'b0;
		wt(RD_HALF);
		for (int i = 15; i >= 0; i--) begin
			if (i < 15) tick(RD_HALF);
			w[i] = i_dout_oe ? i_dout : 1'bx;
		end
	endtask
	task automatic deselect;
		o_cs_n = 1'b1;
		wt(CMD_HALF);
	endtask
endmodule

// ### testbench/tb_top.sv
/* top bench for asc_core, driven through the host model.
   assumes: the checker binds itself in. */
`timescale 1ns/1ps
module tb_top;
	logic clk, rst, ce, hw_rst_n, shdn_n, cs_n, sclk, din, dout, dout_oe;
	logic strb, strb_oe, pol, csel, cal, pdn;
	logic [1:0] mode;
	logic [2:0] gp;
	logic [15:0] smp, w;
	int error_cnt = 0;
	int n_tests = 0;
	asc_core dut (.i_clock(clk), .i_sys_rst(rst), .i_ce(ce), .i_hw_rst_n(hw_rst_n),
		.i_shdn_n(shdn_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_dout(dout),
		.o_dout_oe(dout_oe), .o_conv_strobe(strb), .o_conv_strobe_oe(strb_oe),
		.i_sample(smp), .o_polarity_select(pol), .o_conv_clock_select(csel),
		.o_mode(mode), .o_cal_busy(cal), .o_power_down(pdn), .o_gp_out(gp));
	asc_host host (.i_clock(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din),
		.i_dout(dout), .i_dout_oe(dout_oe));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic summarize;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic conv(input logic [15:0] e);
		chk(16'(strb), 16'h0000);
		host.deselect();
		chk(16'(strb_oe), 16'h0001);
		for (int i = 0; i < 1600 && strb !== 1'b1; i++) begin
			host.wt(1);
		end
		chk(16'(strb), 16'h0001);
		if (strb !== 1'b1) summarize();
		host.read(w);
		chk(w, e);
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		hw_rst_n = 1'b1;
		shdn_n = 1'b1;
		smp = 16'h1234;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		host.wt(4);
		chk(16'({gp, pol, csel}), 16'h0001);
		host.clocks(8, 1'b0);
		chk(16'({gp, strb}), 16'h0001);
		host.send(8'he5);
		chk(16'({gp, pol, csel, mode}), 16'h005c);
		// a low enable freezes the timer, so the strobe outlasts its normal end
		host.wt(750);
		ce = 1'b0;
		host.wt(300);
		chk(16'(strb), 16'h0000);
		ce = 1'b1;
		conv(16'h1234);
		smp = 16'h0f0f;
		host.send(8'ha2);
		chk(16'({gp, pol, csel, mode}), 16'h0024);
		conv(16'h8f0f);
		smp = 16'hc3a5;
		host.deselect();
		host.send(8'hff);
		chk(16'({gp, pol, csel, mode}), 16'h007f);
		conv(16'hc3a5);
		host.deselect();
		host.send(8'ha8);
		chk(16'({gp, cal, strb}), 16'h0002);
		host.deselect();
		smp = 16'h8001;
		host.send(8'ha3);
		chk(16'({gp, cal}), 16'h0006);
		conv(16'h0001);
		host.deselect();
		host.send(8'hb6);
		chk(16'({gp, pdn}), 16'h000d);
		host.deselect();
		shdn_n = 1'b0;
		host.wt(10);
		chk(16'({gp, pdn}), 16'h000d);
		shdn_n = 1'b1;
		host.send(8'hc1);
		host.clocks(15, 1'b0);
		chk(16'({gp, pol, csel, mode}), 16'h0018);
		// a one on the last conversion clock must not be taken as a start bit
		host.clocks(1, 1'b1);
		host.send(8'hc6);
		chk(16'({gp, pol, csel, mode}), 16'h0068);
		host.deselect();
		host.send(8'hdb);
		host.clocks(23, 1'b0);
		chk(16'({gp, pol, csel, mode}), 16'h003b);
		host.clocks(1, 1'b1);
		host.send(8'hc5);
		chk(16'({gp, pol, csel, mode}), 16'h0058);
		host.deselect();
		hw_rst_n = 1'b0;
		host.wt(5);
		hw_rst_n = 1'b1;
		host.wt(4);
		chk(16'({gp, pol, csel}), 16'h0001);
		summarize();
	end
endmodule
